/* File: pgc_top.sv */
`timescale 1ns/10ps
`include "pgc_regs.svh"
module pgc_top (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Plain port side, from data and output control registers
    input  wire pgc_pkg::pgc_pins_t  port_out_i,
    input  wire pgc_pkg::pgc_pins_t  port_oe_i,
    output pgc_pkg::pgc_pins_t       port_in_o,
    // Peripheral outputs toward pins
    input  wire logic                motor_phase_u_out_i,
    input  wire logic                motor_phase_x_out_i,
    input  wire logic                motor_phase_v_out_i,
    input  wire logic                motor_phase_y_out_i,
    input  wire logic                motor_phase_w_out_i,
    input  wire logic                motor_phase_z_out_i,
    input  wire logic                serial1_frame_select_i,
    input  wire logic                serial1_data_out_i,
    input  wire logic                serial1_clock_i,
    input  wire logic                motor_timer_out_a_i,
    input  wire logic                motor_timer_out_b_i,
    input  wire logic                motor_emergency_signal_i,
    input  wire logic                mt_timer_out_i,
    // Peripheral inputs from pins
    output logic                     emergency_stop_in_o,
    output logic                     serial1_data_in_o,
    output logic                     motor_timer_input_o,
    output logic                     mt_timer_in_o,
    // Pads
    input  wire pgc_pkg::pgc_pins_t  pin_i,
    output pgc_pkg::pgc_pins_t       pin_o,
    output pgc_pkg::pgc_pins_t       pin_oe_n_o,
    output pgc_pkg::pgc_pins_t       pin_pullup_o,
    output pgc_pkg::pgc_pins_t       pin_pulldown_o
);
    import pgc_pkg::*;

    pgc_pins_t  fsel_b_q;
    pgc_pins_t  fsel_c_q;
    pgc_pins_t  fsel_d_q;
    pgc_pins_t  drv_type_q;
    pgc_pins_t  pullup_q;
    pgc_pins_t  pulldn_q;
    pgc_pins_t  inp_en_q;

    logic        req;
    logic        wr_commit;
    logic        lane0_wr;
    logic [7:0]  wr_byte;
    logic [7:0]  rd_byte;
    logic [31:0] rd_word_d;

    pgc_src_e    src [8];
    pgc_pins_t   val_b;
    pgc_pins_t   val_c;
    pgc_pins_t   val_d;
    pgc_pins_t   drv_val;
    pgc_pins_t   drv_en;
    pgc_pins_t   cell_in;
    pgc_pins_t   outs_b;
    pgc_pins_t   outs_c;
    pgc_pins_t   outs_d;

    // One write strobe per register keeps the address decode in one place
    logic        wr_fsel_b;
    logic        wr_fsel_c;
    logic        wr_fsel_d;
    logic        wr_drv_type;
    logic        wr_pullup;
    logic        wr_pulldn;
    logic        wr_inp_en;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: ack one cycle after the request is seen, dropped after.
    // The write lands on the edge where the master samples ack, so a
    // master that aborts early never changes a register.
    assign req       = wb_cyc_i & wb_stb_i;
    assign wr_commit = req & wb_we_i & wb_ack_o;
    assign lane0_wr  = wr_commit & wb_sel_i[0];
    assign wr_byte   = wb_dat_i[7:0];

    // Only the low lane carries settings; other lanes cannot reach a register
    assign wr_fsel_b   = lane0_wr & (wb_adr_i == `PGC_OFF_FSEL_B);
    assign wr_fsel_c   = lane0_wr & (wb_adr_i == `PGC_OFF_FSEL_C);
    assign wr_fsel_d   = lane0_wr & (wb_adr_i == `PGC_OFF_FSEL_D);
    assign wr_drv_type = lane0_wr & (wb_adr_i == `PGC_OFF_DRV_TYPE);
    assign wr_pullup   = lane0_wr & (wb_adr_i == `PGC_OFF_PULLUP);
    assign wr_pulldn   = lane0_wr & (wb_adr_i == `PGC_OFF_PULLDN);
    assign wr_inp_en   = lane0_wr & (wb_adr_i == `PGC_OFF_INP_EN);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers, one block each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fsel_b_q <= `PGC_RESET_VAL;
        end else if (wr_fsel_b) begin
            fsel_b_q <= wr_byte & `PGC_MASK_FSEL_B;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fsel_c_q <= `PGC_RESET_VAL;
        end else if (wr_fsel_c) begin
            fsel_c_q <= wr_byte & `PGC_MASK_FSEL_C;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fsel_d_q <= `PGC_RESET_VAL;
        end else if (wr_fsel_d) begin
            fsel_d_q <= wr_byte & `PGC_MASK_FSEL_D;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_type_q <= `PGC_RESET_VAL;
        end else if (wr_drv_type) begin
            drv_type_q <= wr_byte & `PGC_MASK_FULL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_q <= `PGC_RESET_VAL;
        end else if (wr_pullup) begin
            pullup_q <= wr_byte & `PGC_MASK_FULL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulldn_q <= `PGC_RESET_VAL;
        end else if (wr_pulldn) begin
            pulldn_q <= wr_byte & `PGC_MASK_FULL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inp_en_q <= `PGC_RESET_VAL;
        end else if (wr_inp_en) begin
            inp_en_q <= wr_byte & `PGC_MASK_FULL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read side. Reserved and unmapped words answer with zero rather than
    // an error, so a stray access cannot hang the bus.
    always_comb begin
        case (wb_adr_i)
            `PGC_OFF_FSEL_B:   rd_byte = fsel_b_q;
            `PGC_OFF_FSEL_C:   rd_byte = fsel_c_q;
            `PGC_OFF_FSEL_D:   rd_byte = fsel_d_q;
            `PGC_OFF_DRV_TYPE: rd_byte = drv_type_q;
            `PGC_OFF_PULLUP:   rd_byte = pullup_q;
            `PGC_OFF_PULLDN:   rd_byte = pulldn_q;
            `PGC_OFF_INP_EN:   rd_byte = inp_en_q;
            default:           rd_byte = `PGC_RESET_VAL;
        endcase
        rd_word_d = {`PGC_ZERO_HI, rd_byte};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= {`PGC_ZERO_HI, `PGC_RESET_VAL};
        end else if (req && !wb_we_i && !wb_ack_o) begin
            wb_dat_o <= rd_word_d;
        end else begin
            wb_dat_o <= {`PGC_ZERO_HI, `PGC_RESET_VAL};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Function selection per pin. Should software set several select bits
    // for one pin, the highest register wins: D over C over B.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (fsel_d_q[i]) begin
                src[i] = PGC_SRC_D;
            end else if (fsel_c_q[i]) begin
                src[i] = PGC_SRC_C;
            end else if (fsel_b_q[i]) begin
                src[i] = PGC_SRC_B;
            end else begin
                src[i] = PGC_SRC_PORT;
            end
        end
    end

    // Peripheral output values in pin order 7..0
    always_comb begin
        val_b = {motor_phase_u_out_i, motor_phase_x_out_i,
                 motor_phase_v_out_i, motor_phase_y_out_i,
                 motor_phase_w_out_i, motor_phase_z_out_i,
                 2'b00};
        val_c = {serial1_frame_select_i, 1'b0,
                 serial1_data_out_i, serial1_clock_i,
                 motor_timer_out_a_i, motor_timer_out_b_i,
                 motor_emergency_signal_i, 1'b0};
        val_d = {4'h0, mt_timer_out_i, 3'h0};
    end

    // Which pins each function register turns into outputs; the rest are inputs
    assign outs_b = `PGC_OUTS_B;
    assign outs_c = `PGC_OUTS_C;
    assign outs_d = `PGC_OUTS_D;

    // Pins given to a peripheral input are never driven by this block
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            case (src[i])
                PGC_SRC_PORT: begin
                    drv_val[i] = port_out_i[i];
                    drv_en[i]  = port_oe_i[i];
                end
                PGC_SRC_B: begin
                    drv_val[i] = val_b[i];
                    drv_en[i]  = outs_b[i];
                end
                PGC_SRC_C: begin
                    drv_val[i] = val_c[i];
                    drv_en[i]  = outs_c[i];
                end
                PGC_SRC_D: begin
                    drv_val[i] = val_d[i];
                    drv_en[i]  = outs_d[i];
                end
                default: begin
                    drv_val[i] = 1'b0;
                    drv_en[i]  = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad cells
    for (genvar g = 0; g < 8; g++) begin : g_pin
        pgc_pin_cell u_cell (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .pin_i        (pin_i[g]),
            .drv_val_i    (drv_val[g]),
            .drv_en_i     (drv_en[g]),
            .open_drain_i (drv_type_q[g]),
            .in_en_i      (inp_en_q[g]),
            .pullup_i     (pullup_q[g]),
            .pulldown_i   (pulldn_q[g]),
            .pin_o        (pin_o[g]),
            .pin_oe_n_o   (pin_oe_n_o[g]),
            .in_o         (cell_in[g]),
            .pullup_o     (pin_pullup_o[g]),
            .pulldown_o   (pin_pulldown_o[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input fan-out. Peripherals see a pin only while it is routed to them;
    // otherwise they read low. The port view always follows input enable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_in_o <= `PGC_RESET_VAL;
        end else begin
            port_in_o <= cell_in;
        end
    end

    // Emergency input: pin 1 under select B only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            emergency_stop_in_o <= 1'b0;
        end else begin
            emergency_stop_in_o <= cell_in[`PGC_PIN_EMG]
                                 & (src[`PGC_PIN_EMG] == PGC_SRC_B);
        end
    end

    // Serial 1 data in: pin 6 under select C only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial1_data_in_o <= 1'b0;
        end else begin
            serial1_data_in_o <= cell_in[`PGC_PIN_SDI]
                               & (src[`PGC_PIN_SDI] == PGC_SRC_C);
        end
    end

    // Motor timer input: pin 0 under select C only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motor_timer_input_o <= 1'b0;
        end else begin
            motor_timer_input_o <= cell_in[`PGC_PIN_MTIN]
                                 & (src[`PGC_PIN_MTIN] == PGC_SRC_C);
        end
    end

    // Timer capture input: pin 2 under select D only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mt_timer_in_o <= 1'b0;
        end else begin
            mt_timer_in_o <= cell_in[`PGC_PIN_TBIN]
                           & (src[`PGC_PIN_TBIN] == PGC_SRC_D);
        end
    end
endmodule

/* File: pgc_regs.svh */
`ifndef PGC_REGS_SVH
`define PGC_REGS_SVH

`define PGC_ADR_W        8
`define PGC_OFF_FSEL_B   8'h0c
`define PGC_OFF_FSEL_C   8'h10
`define PGC_OFF_FSEL_D   8'h14
`define PGC_OFF_DRV_TYPE 8'h28
`define PGC_OFF_PULLUP   8'h2c
`define PGC_OFF_PULLDN   8'h30
`define PGC_OFF_INP_EN   8'h38

`define PGC_MASK_FSEL_B  8'hfe
`define PGC_MASK_FSEL_C  8'hff
`define PGC_MASK_FSEL_D  8'h0c
`define PGC_MASK_FULL    8'hff
`define PGC_RESET_VAL    8'h00
`define PGC_ZERO_HI      24'h000000

`define PGC_OUTS_B       8'hfc
`define PGC_OUTS_C       8'hbe
`define PGC_OUTS_D       8'h08

`define PGC_PIN_EMG      1
`define PGC_PIN_SDI      6
`define PGC_PIN_MTIN     0
`define PGC_PIN_TBIN     2

`endif

/* File: pgc_pkg.sv */
package pgc_pkg;
    typedef logic [7:0] pgc_pins_t;
    typedef enum logic [1:0] {
        PGC_SRC_PORT,
        PGC_SRC_B,
        PGC_SRC_C,
        PGC_SRC_D
    } pgc_src_e;
endpackage

/* File: pgc_pin_cell.sv */
`timescale 1ns/10ps
module pgc_pin_cell (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    input  wire logic drv_val_i,
    input  wire logic drv_en_i,
    input  wire logic open_drain_i,
    input  wire logic in_en_i,
    input  wire logic pullup_i,
    input  wire logic pulldown_i,
    output logic      pin_o,
    output logic      pin_oe_n_o,
    output logic      in_o,
    output logic      pullup_o,
    output logic      pulldown_o
);
    logic sync1_q;
    logic sync2_q;
    logic out_d;
    logic oe_n_d;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input: two flops before anything looks at it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    // Disabled input reads low so a floating pin cannot toggle logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_o <= 1'b0;
        end else begin
            in_o <= sync2_q & in_en_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open drain only ever pulls low; a high is left to the board
    always_comb begin
        out_d  = drv_val_i & ~open_drain_i;
        oe_n_d = ~(drv_en_i & (~open_drain_i | ~drv_val_i));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o      <= 1'b0;
            pin_oe_n_o <= 1'b1;
        end else begin
            pin_o      <= out_d;
            pin_oe_n_o <= oe_n_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_o   <= 1'b0;
            pulldown_o <= 1'b0;
        end else begin
            pullup_o   <= pullup_i;
            pulldown_o <= pulldown_i;
        end
    end
endmodule

/* File: pgc_props.sv */
`timescale 1ns/10ps
module pgc_props (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [31:0]        wb_dat_o,
    input  wire logic               wb_ack_o,
    input  wire pgc_pkg::pgc_pins_t pin_o,
    input  wire pgc_pkg::pgc_pins_t pin_oe_n_o,
    input  wire pgc_pkg::pgc_pins_t pin_pullup_o,
    input  wire pgc_pkg::pgc_pins_t pin_pulldown_o
);
    import pgc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_b;
    logic rd_d;
    logic wr_pu;
    logic wr_pd;
    // Master holds address and direction through the ack cycle, so they qualify it
    assign rd_b  = wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c;
    assign rd_d  = wb_ack_o && !wb_we_i && wb_adr_i == 8'h14;
    assign wr_pu = wb_ack_o && wb_we_i && wb_adr_i == 8'h2c;
    assign wr_pd = wb_ack_o && wb_we_i && wb_adr_i == 8'h30;
    ////////////////////////////////////////////////////////////////////////////
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_on_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    high_zero_a: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    sel_b_bit0_a: assert property (rd_b |-> wb_dat_o[0] == 1'b0) else $error("select b bit 0 set");
    sel_d_rsvd_a: assert property (rd_d |-> wb_dat_o[7:4] == 4'h0 && wb_dat_o[1:0] == 2'h0)
        else $error("select d reserved bits set");
    pullup_src_a: assert property ($changed(pin_pullup_o) |-> $past(wr_pu) || $past(wr_pu, 2))
        else $error("pull-up moved without write");
    pulldn_src_a: assert property ($changed(pin_pulldown_o) |-> $past(wr_pd) || $past(wr_pd, 2))
        else $error("pull-down moved without write");
    reset_clear_a: assert property ($fell(rst_i) |-> !wb_ack_o && pin_o == 8'h00 && pin_oe_n_o == 8'hff
        && pin_pullup_o == 8'h00 && pin_pulldown_o == 8'h00) else $error("state not clear after reset");
    wr_seen_c: cover property (wb_ack_o && wb_we_i);
    rd_seen_c: cover property (wb_ack_o && !wb_we_i);
    pull_seen_c: cover property (pin_pullup_o != 8'h00);
endmodule
bind pgc_top pgc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o), .pin_pulldown_o(pin_pulldown_o));

/* File: pgc_board_model.sv */
`timescale 1ns/10ps
module pgc_board_model (
    input  wire logic               clk_i,
    input  wire pgc_pkg::pgc_pins_t pad_out_i,
    input  wire pgc_pkg::pgc_pins_t pad_oe_n_i,
    input  wire pgc_pkg::pgc_pins_t pullup_i,
    input  wire pgc_pkg::pgc_pins_t pulldown_i,
    input  wire pgc_pkg::pgc_pins_t ext_val_i,
    input  wire pgc_pkg::pgc_pins_t ext_en_i,
    output pgc_pkg::pgc_pins_t      pad_o
);
    import pgc_pkg::*;
    logic flip_q = 1'b0;
    always @(posedge clk_i) begin
        flip_q <= ~flip_q;
    end
    // A floating pad wanders each cycle so a missing pull is never read as a lucky 0
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n_i[i]) begin
                pad_o[i] = pad_out_i[i];
            end else if (ext_en_i[i]) begin
                pad_o[i] = ext_val_i[i];
            end else if (pullup_i[i]) begin
                pad_o[i] = 1'b1;
            end else if (pulldown_i[i]) begin
                pad_o[i] = 1'b0;
            end else begin
                pad_o[i] = flip_q ^ i[0];
            end
        end
    end
endmodule

/* File: tb_port_g_pin_config.sv */
`timescale 1ns/10ps
module tb_port_g_pin_config;
    import pgc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [3:0]  sel   = 4'h0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wd    = 32'h0;
    logic [12:0] per   = 13'h0;
    pgc_pins_t   pout  = 8'h00;
    pgc_pins_t   poe   = 8'h00;
    pgc_pins_t   ext_v = 8'h00;
    pgc_pins_t   ext_e = 8'h00;
    logic [31:0] rd;
    logic        ack;
    logic [3:0]  ins;
    pgc_pins_t   pin_in, pin_out, oe_n, pup, pdn, pin_rd;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [7:0]  offs [7] = '{8'h0c, 8'h10, 8'h14, 8'h28, 8'h2c, 8'h30, 8'h38};
    logic [7:0]  msk [7]  = '{8'hfe, 8'hff, 8'h0c, 8'hff, 8'hff, 8'hff, 8'hff};
    pgc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .port_out_i(pout), .port_oe_i(poe),
        .port_in_o(pin_rd), .motor_phase_u_out_i(per[12]), .motor_phase_x_out_i(per[11]),
        .motor_phase_v_out_i(per[10]), .motor_phase_y_out_i(per[9]), .motor_phase_w_out_i(per[8]),
        .motor_phase_z_out_i(per[7]), .serial1_frame_select_i(per[6]), .serial1_data_out_i(per[5]),
        .serial1_clock_i(per[4]), .motor_timer_out_a_i(per[3]), .motor_timer_out_b_i(per[2]),
        .motor_emergency_signal_i(per[1]), .mt_timer_out_i(per[0]), .emergency_stop_in_o(ins[3]),
        .serial1_data_in_o(ins[2]), .motor_timer_input_o(ins[1]), .mt_timer_in_o(ins[0]), .pin_i(pin_in),
        .pin_o(pin_out), .pin_oe_n_o(oe_n), .pin_pullup_o(pup), .pin_pulldown_o(pdn));
    pgc_board_model u_board (.clk_i(clk_i), .pad_out_i(pin_out), .pad_oe_n_i(oe_n), .pullup_i(pup),
        .pulldown_i(pdn), .ext_val_i(ext_v), .ext_en_i(ext_e), .pad_o(pin_in));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pad(input logic [7:0] got, input logic [7:0] exp);
        chk_reg({24'h0, got}, {24'h0, exp});
    endtask
    // Classic cycle: request held until ack is sampled, then one idle cycle.
    // No wait limit here; a hang is ended by the cycle ceiling.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        sel <= 4'hf;
        adr <= a;
        wd  <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk_reg(r, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 7; i++) rdc(offs[i], 32'h0);
        chk_pad(oe_n, 8'hff);
        chk_pad({pup | pdn}, 8'h00);
        chk_pad({4'h0, ins}, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_regs;
        for (int i = 0; i < 7; i++) begin
            wr(offs[i], 32'hffffffff);
            rdc(offs[i], {24'h0, msk[i]});
            wr(offs[i], 32'h0);
            rdc(offs[i], 32'h0);
        end
        wr(8'h40, 32'hffffffff);
        rdc(8'h40, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_input;
        ext_e <= 8'hff;
        ext_v <= 8'h3c;
        repeat (6) @(posedge clk_i);
        chk_pad(pin_rd, 8'h00);
        wr(8'h38, 32'hff);
        repeat (6) @(posedge clk_i);
        chk_pad(pin_rd, 8'h3c);
        $display("t_input done");
    endtask
    task automatic t_pulls;
        ext_e <= 8'h00;
        wr(8'h2c, 32'ha5);
        wr(8'h30, 32'h5a);
        repeat (6) @(posedge clk_i);
        chk_pad(pup, 8'ha5);
        chk_pad(pdn, 8'h5a);
        chk_pad(pin_rd, 8'ha5);
        wr(8'h2c, 32'h0);
        wr(8'h30, 32'h0);
        $display("t_pulls done");
    endtask
    task automatic t_drain;
        poe  <= 8'hff;
        pout <= 8'h0f;
        repeat (3) @(posedge clk_i);
        chk_pad(oe_n, 8'h00);
        chk_pad(pin_out, 8'h0f);
        wr(8'h28, 32'hff);
        repeat (3) @(posedge clk_i);
        chk_pad(oe_n, 8'h0f);
        chk_pad(pin_out, 8'h00);
        wr(8'h28, 32'h0);
        poe <= 8'h00;
        $display("t_drain done");
    endtask
    // Undriven pins are fed from the board; only routed inputs are set high
    task automatic route(input logic [7:0] a, v, oen, om, oexp, inp, input logic [3:0] iexp);
        ext_e <= oen;
        ext_v <= inp;
        wr(a, {24'h0, v});
        repeat (6) @(posedge clk_i);
        chk_pad(oe_n, oen);
        chk_pad(pin_out & om, oexp);
        chk_pad({4'h0, ins}, {4'h0, iexp});
        wr(a, 32'h0);
    endtask
    // Reset in mid-run must clear settings that were live before it
    task automatic t_mid_reset;
        wr(8'h2c, 32'hff);
        wr(8'h10, 32'hff);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        $display("t_mid_reset done");
    endtask
    task automatic t_func;
        per <= 13'h156b;
        route(8'h0c, 8'hfe, 8'h03, 8'hfc, 8'ha8, 8'h02, 4'h8);
        route(8'h10, 8'hff, 8'h41, 8'hbe, 8'haa, 8'h41, 4'h6);
        route(8'h14, 8'h0c, 8'hf7, 8'h08, 8'h08, 8'h04, 4'h1);
        $display("t_func done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_regs();
        t_input();
        t_pulls();
        t_drain();
        t_func();
        t_mid_reset();
        report_and_stop();
    end
endmodule
